// ### bench/rcc_chop_ctrl_tb.sv
`timescale 1ns/100ps
module rcc_chop_ctrl_tb;
  import rcc_pkg::*;

  // ****************************************************************
  // Compare macro.
  // ****************************************************************
  `define CHK(nm, ex, got) \
    begin \
      compares++; \
      if ((got) !== (ex)) \
      begin \
        bad_count++; \
        $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
      end \
    end

  int bad_count = 0;
  int compares = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] temp_sample = 16'h0000;
  logic [18:0] fuse_bits = 19'h00000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ref_chop;
  logic alt_cycle;
  logic [31:0] gain_adjust;
  logic compute_irq;
  logic accum_irq;
  logic [31:0] seed = 32'hb3c2317b;
  logic [31:0] rd;
  logic [31:0] v;
  logic er;
  logic [3:0] d;
  logic prev;
  int n;

  always #10 clk = ~clk;

  rcc_chop_ctrl dut (.SYS_CLK(clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TEMP_SAMPLE(temp_sample),
    .FUSE_BITS(fuse_bits), .REF_CHOP(ref_chop), .ALT_CYCLE(alt_cycle),
    .GAIN_ADJUST(gain_adjust), .COMPUTE_IRQ(compute_irq), .ACCUM_IRQ(accum_irq));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    return seed;
  endfunction

  // Only non-negative operands are used, so the arithmetic shifts stay exact.
  function automatic logic [31:0] exp_gain(input longint lin, input longint quad,
                                           input longint dt);
    return 32'((lin * dt) >>> 8) + 32'((quad * dt * dt) >>> 16);
  endfunction

  function automatic logic [31:0] exp_fuse(input logic [7:0] sel, input logic [18:0] f);
    return (sel == FUSE_IDX_COARSE) ? {29'h0, f[18:16]} :
      (sel == FUSE_IDX_BG_A) ? {24'h0, f[7:0]} :
      (sel == FUSE_IDX_BG_B) ? {24'h0, f[15:8]} : 32'h0000_0000;
  endfunction

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH apb ready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic clks(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    fuse_bits <= 19'(rnd());
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Registers, fuse readback and refusal.
    apb(1'b0, IDX_TEMP_SOURCE, 32'h0);
    `CHK("source reset", SOURCE_RESET, rd)
    for (int i = 3; i < 8; i++)
    begin
      apb(1'b1, IDX_FUSE_SELECT, 32'(i));
      apb(1'b0, IDX_FUSE_SELECT, 32'h0);
      `CHK("fuse select", 32'(i), rd)
      apb(1'b0, IDX_FUSE_READBACK, 32'h0);
      `CHK("fuse readback", exp_fuse(8'(i), fuse_bits), rd)
    end
    apb(1'b0, 14'h0100, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    // Fixed and automatic chop codes.
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, IDX_CONTROL, 32'(c));
      clks(130);
      if (c == 1 || c == 2)
        `CHK("fixed chop", (c == 2), ref_chop)
      else
      begin
        prev = ref_chop;
        clks(64);
        `CHK("auto toggle", ~prev, ref_chop)
      end
    end
    $display("test chop codes done");
    // Interrupt pulse counts.
    n = 0;
    for (int i = 0; i < 640; i++)
    begin
      clks(1);
      n += (compute_irq === 1'b1);
    end
    `CHK("compute irq", 10, n)
    n = 0;
    for (int i = 0; i < 1024; i++)
    begin
      clks(1);
      n += (accum_irq === 1'b1);
    end
    `CHK("accum irq", 2, n)
    $display("test interrupts done");
    // Alternate cycle with internal compensation, then a mid-cycle write.
    d = 4'(rnd());
    apb(1'b1, IDX_TEMP_SOURCE, SOURCE_INTERNAL);
    apb(1'b1, IDX_LINEAR_COEFF, 32'h0100);
    apb(1'b1, IDX_QUAD_COEFF, 32'h0100);
    apb(1'b1, IDX_TEMP_REF, 32'h0040);
    temp_sample <= 16'h0040 + d;
    apb(1'b1, IDX_CONTROL, 32'h7);
    n = 0;
    while (alt_cycle !== 1'b1 && n < 200)
    begin
      clks(1);
      n++;
    end
    `CHK("alt polarity", 1'b0, ref_chop)
    n = 0;
    while (alt_cycle === 1'b1 && n < 100)
    begin
      clks(1);
      n++;
    end
    `CHK("alt length", 64, n)
    `CHK("after alt", 1'b1, ref_chop)
    apb(1'b1, IDX_CONTROL, 32'h1);
    clks(30);
    `CHK("mid-cycle hold", 1'b1, ref_chop)
    `CHK("gain computed", exp_gain(256, 256, d), gain_adjust)
    apb(1'b0, IDX_TEMP_READING, 32'h0);
    `CHK("temp reading", 32'h0040 + d, rd)
    clks(40);
    `CHK("next cycle", 1'b0, ref_chop)
    apb(1'b1, IDX_CONTROL, 32'h3);
    $display("test alternate cycle done");
    // Host-supplied gain.
    v = rnd();
    apb(1'b1, IDX_TEMP_SOURCE, SOURCE_EXTERNAL);
    apb(1'b1, IDX_GAIN_ADJUST, v);
    clks(2);
    `CHK("host gain", v, gain_adjust)
    apb(1'b0, IDX_GAIN_ADJUST, 32'h0);
    `CHK("gain read", v, rd)
    $display("test host gain done");
    report_and_stop();
  end
endmodule

// ### inc/rcc_pkg.sv
package rcc_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [13:0] IDX_GAIN_ADJUST = 14'h002e;
  localparam logic [13:0] IDX_TEMP_SOURCE = 14'h0038;
  localparam logic [13:0] IDX_FUSE_SELECT = 14'h20fd;
  localparam logic [13:0] IDX_FUSE_READBACK = 14'h20ff;
  localparam logic [13:0] IDX_CONTROL = 14'h2000;
  localparam logic [13:0] IDX_STATUS = 14'h2001;
  localparam logic [13:0] IDX_LINEAR_COEFF = 14'h0030;
  localparam logic [13:0] IDX_QUAD_COEFF = 14'h0031;
  localparam logic [13:0] IDX_TEMP_REF = 14'h0032;
  localparam logic [13:0] IDX_TEMP_READING = 14'h0033;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int CTL_CHOP_LSB = 0;
  localparam int CTL_ALT_REQ = 2;
  localparam logic [1:0] CHOP_RESET = 2'h3;
  localparam logic [31:0] SOURCE_RESET = 32'h0000_0000;
  localparam logic [31:0] SOURCE_INTERNAL = 32'h0000_0000;
  localparam logic [31:0] SOURCE_EXTERNAL = 32'h0000_000f;
  localparam logic [7:0] FUSE_IDX_COARSE = 8'h04;
  localparam logic [7:0] FUSE_IDX_BG_A = 8'h05;
  localparam logic [7:0] FUSE_IDX_BG_B = 8'h06;

  // ****************************************************************
  // Chop select codes.
  // ****************************************************************
  typedef enum logic [1:0] {
    RCC_CHOP_AUTO0 = 2'b00,
    RCC_CHOP_POS = 2'b01,
    RCC_CHOP_REV = 2'b10,
    RCC_CHOP_AUTO1 = 2'b11
  } rcc_chop_e;

  // ****************************************************************
  // Timing counts; ACC_CYCLES is in multiplexer cycles, the others in system clocks.
  // ****************************************************************
  localparam logic [7:0] MUX_CYCLE_CLKS = 8'h40;
  localparam logic [7:0] COMPUTE_CLKS = 8'h20;
  localparam logic [7:0] ACC_CYCLES = 8'h08;

endpackage

// ### src/rcc_chop_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - 00/11 toggle chop; 01 positive; 10 reversed.
// - Chop high swaps reference amplifier inputs.
// - Alternate-mux request inserts one alternate cycle.
// - Automatic chop runs alternate cycle positive.
// - Source 0: engine computes gain from coefficients.
// - Source 15: host supplies gain word.
// - Fuse index 4/5/6 selects readback value.
// - Select written mid-cycle applies next cycle.
// - Interrupts fire on busy falling edges.
module rcc_chop_ctrl
  import rcc_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave.
  input wire logic [15:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Converter side.
  input wire logic [15:0] TEMP_SAMPLE,
  input wire logic [18:0] FUSE_BITS,
  output logic REF_CHOP,
  output logic ALT_CYCLE,
  output logic [31:0] GAIN_ADJUST,
  // Interrupt pulses to the host processor.
  output logic COMPUTE_IRQ,
  output logic ACCUM_IRQ
);

  logic bnd;
  logic compute_busy;
  logic [1:0] chop_select;
  logic alt_req;
  logic [1:0] chop_q;
  logic alt_pend;
  logic [31:0] temp_source;
  logic [7:0] fuse_select;
  logic [15:0] linear_temp_coeff;
  logic [15:0] quadratic_temp_coeff;
  logic [15:0] temp_ref;
  logic [15:0] temp_reading;
  logic [18:0] fuse_meta;
  logic [18:0] fuse_sync;
  logic [7:0] acc_count;
  logic accum_busy;
  logic compute_busy_q;
  logic accum_busy_q;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [7:0] fuse_value;
  logic take_alt;

  function automatic logic [15:0] byte_addr(input logic [13:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic is_auto(input logic [1:0] code);
    is_auto = (code == RCC_CHOP_AUTO0) || (code == RCC_CHOP_AUTO1);
  endfunction

  // The squared term is scaled harder than the linear one, so a large
  // quadratic coefficient cannot swamp the gain word near the reference.
  function automatic logic [31:0] gain_calc(input logic [15:0] t, input logic [15:0] r,
                                            input logic [15:0] lin, input logic [15:0] quad);
    logic signed [16:0] delta;
    logic signed [33:0] lin_term;
    logic signed [50:0] quad_term;
    delta = $signed({t[15], t}) - $signed({r[15], r});
    lin_term = 34'($signed(lin) * delta);
    quad_term = 51'($signed(quad) * delta * delta);
    gain_calc = 32'(lin_term >>> 8) + 32'(quad_term >>> 16);
  endfunction

  rcc_mux_timer u_timer (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .boundary(bnd),
    .compute_busy(compute_busy)
  );

  // ****************************************************************
  // APB access.
  // ****************************************************************
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign take_alt = bnd && alt_req;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (PADDR)
      byte_addr(IDX_GAIN_ADJUST): rd_data = GAIN_ADJUST;
      byte_addr(IDX_TEMP_SOURCE): rd_data = temp_source;
      byte_addr(IDX_FUSE_SELECT): rd_data = {24'h000000, fuse_select};
      byte_addr(IDX_FUSE_READBACK): rd_data = {24'h000000, fuse_value};
      byte_addr(IDX_CONTROL): rd_data = {29'h0, alt_req, chop_select};
      byte_addr(IDX_STATUS): rd_data = {21'h0, acc_count, alt_pend, ALT_CYCLE, REF_CHOP};
      byte_addr(IDX_LINEAR_COEFF): rd_data = {16'h0000, linear_temp_coeff};
      byte_addr(IDX_QUAD_COEFF): rd_data = {16'h0000, quadratic_temp_coeff};
      byte_addr(IDX_TEMP_REF): rd_data = {16'h0000, temp_ref};
      byte_addr(IDX_TEMP_READING): rd_data = {16'h0000, temp_reading};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    case (fuse_select)
      FUSE_IDX_COARSE: fuse_value = {5'h00, fuse_sync[18:16]};
      FUSE_IDX_BG_A: fuse_value = fuse_sync[7:0];
      FUSE_IDX_BG_B: fuse_value = fuse_sync[15:8];
      default: fuse_value = 8'h00;
    endcase
  end

  // One wait state keeps every APB output a plain flip-flop.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !rd_hit;
      PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      chop_select <= CHOP_RESET;
      temp_source <= SOURCE_RESET;
      fuse_select <= 8'h00;
      linear_temp_coeff <= 16'h0000;
      quadratic_temp_coeff <= 16'h0000;
      temp_ref <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (PADDR)
        byte_addr(IDX_CONTROL): chop_select <= PWDATA[CTL_CHOP_LSB +: 2];
        byte_addr(IDX_TEMP_SOURCE): temp_source <= PWDATA;
        byte_addr(IDX_FUSE_SELECT): fuse_select <= PWDATA[7:0];
        byte_addr(IDX_LINEAR_COEFF): linear_temp_coeff <= PWDATA[15:0];
        byte_addr(IDX_QUAD_COEFF): quadratic_temp_coeff <= PWDATA[15:0];
        byte_addr(IDX_TEMP_REF): temp_ref <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // A request written in the boundary cycle is kept: the set wins.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      alt_req <= 1'b0;
    else if (wr_en && PADDR == byte_addr(IDX_CONTROL) && PWDATA[CTL_ALT_REQ])
      alt_req <= 1'b1;
    else if (take_alt)
      alt_req <= 1'b0;
  end

  // ****************************************************************
  // Chop polarity and alternate cycle sequencing.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      chop_q <= CHOP_RESET;
      alt_pend <= 1'b0;
      ALT_CYCLE <= 1'b0;
      REF_CHOP <= 1'b0;
    end
    else if (bnd)
    begin
      chop_q <= chop_select;
      alt_pend <= alt_req;
      ALT_CYCLE <= alt_req;
      case (chop_select)
        RCC_CHOP_POS: REF_CHOP <= 1'b0;
        RCC_CHOP_REV: REF_CHOP <= 1'b1;
        default: REF_CHOP <= alt_req ? 1'b0 : !REF_CHOP;
      endcase
    end
  end

  // ****************************************************************
  // Temperature reading and gain adjust word.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      temp_reading <= 16'h0000;
      GAIN_ADJUST <= 32'h0000_0000;
    end
    else
    begin
      if (bnd && ALT_CYCLE)
        temp_reading <= TEMP_SAMPLE;
      if (bnd && ALT_CYCLE && temp_source == SOURCE_INTERNAL)
        GAIN_ADJUST <= gain_calc(TEMP_SAMPLE, temp_ref, linear_temp_coeff,
                                 quadratic_temp_coeff);
      else if (wr_en && PADDR == byte_addr(IDX_GAIN_ADJUST))
        GAIN_ADJUST <= PWDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fuse_meta <= 19'h00000;
      fuse_sync <= 19'h00000;
    end
    else
    begin
      fuse_meta <= FUSE_BITS;
      fuse_sync <= fuse_meta;
    end
  end

  // ****************************************************************
  // Accumulation and interrupt pulses.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      acc_count <= 8'h00;
      accum_busy <= 1'b0;
    end
    else
    begin
      if (bnd && !alt_req)
        acc_count <= (acc_count == ACC_CYCLES - 8'h01) ? 8'h00 : acc_count + 8'h01;
      if (bnd && !alt_req && acc_count == ACC_CYCLES - 8'h01)
        accum_busy <= 1'b1;
      else if (!compute_busy)
        accum_busy <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      compute_busy_q <= 1'b0;
      accum_busy_q <= 1'b0;
      COMPUTE_IRQ <= 1'b0;
      ACCUM_IRQ <= 1'b0;
    end
    else
    begin
      compute_busy_q <= compute_busy;
      accum_busy_q <= accum_busy;
      COMPUTE_IRQ <= compute_busy_q && !compute_busy;
      ACCUM_IRQ <= accum_busy_q && !accum_busy;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_bnd_auto;
    bnd && is_auto(chop_select) && !alt_req;
  endsequence

  sequence s_take_alt;
    bnd && alt_req && is_auto(chop_select);
  endsequence

  property p_auto_toggle;
    @(posedge SYS_CLK) disable iff (!RST_N) s_bnd_auto |=> REF_CHOP != $past(REF_CHOP);
  endproperty
  a_auto_toggle: assert property (p_auto_toggle) else $error("auto chop did not toggle");

  property p_fixed_rev;
    @(posedge SYS_CLK) disable iff (!RST_N)
      bnd && chop_select == RCC_CHOP_REV |=> (REF_CHOP && !bnd)[*8];
  endproperty
  a_fixed_rev: assert property (p_fixed_rev) else $error("reversed chop not held");

  property p_stable_in_cycle;
    @(posedge SYS_CLK) disable iff (!RST_N) !bnd |=> $stable(REF_CHOP) && $stable(ALT_CYCLE);
  endproperty
  a_stable_in_cycle: assert property (p_stable_in_cycle) else $error("chop moved mid-cycle");

  property p_alt_positive;
    @(posedge SYS_CLK) disable iff (!RST_N) s_take_alt |=> ALT_CYCLE && !REF_CHOP;
  endproperty
  a_alt_positive: assert property (p_alt_positive) else $error("alternate cycle not positive");

  property p_alt_insert;
    @(posedge SYS_CLK) disable iff (!RST_N)
      bnd && alt_req && !(wr_en && PADDR == byte_addr(IDX_CONTROL) && PWDATA[CTL_ALT_REQ])
      |=> ALT_CYCLE && !alt_req;
  endproperty
  a_alt_insert: assert property (p_alt_insert) else $error("alternate cycle not inserted");

  property p_late_select;
    @(posedge SYS_CLK) disable iff (!RST_N)
      wr_en && PADDR == byte_addr(IDX_CONTROL) && !bnd |=> chop_q == $past(chop_q);
  endproperty
  a_late_select: assert property (p_late_select) else $error("select applied early");

  property p_gain_internal;
    @(posedge SYS_CLK) disable iff (!RST_N)
      bnd && ALT_CYCLE && temp_source == SOURCE_INTERNAL |=>
      GAIN_ADJUST == gain_calc($past(TEMP_SAMPLE), $past(temp_ref), $past(linear_temp_coeff),
                               $past(quadratic_temp_coeff));
  endproperty
  a_gain_internal: assert property (p_gain_internal) else $error("gain not computed");

  property p_gain_external;
    @(posedge SYS_CLK) disable iff (!RST_N)
      temp_source == SOURCE_EXTERNAL && wr_en && PADDR == byte_addr(IDX_GAIN_ADJUST)
      |=> GAIN_ADJUST == $past(PWDATA);
  endproperty
  a_gain_external: assert property (p_gain_external) else $error("host gain not applied");

  property p_fuse_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
      PSEL && PENABLE && !PREADY && !PWRITE && PADDR == byte_addr(IDX_FUSE_READBACK)
      && fuse_select == FUSE_IDX_BG_A |=> PREADY && PRDATA == {24'h000000, $past(fuse_sync[7:0])};
  endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("fuse readback wrong");

  property p_irq_fall;
    @(posedge SYS_CLK) disable iff (!RST_N)
      $fell(compute_busy) |=> COMPUTE_IRQ ##1 !COMPUTE_IRQ;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("compute interrupt missing");

endmodule

// ### src/rcc_mux_timer.sv
`timescale 1ns/100ps
module rcc_mux_timer
  import rcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Cycle timing.
  output logic boundary,
  output logic compute_busy
);

  logic [7:0] count;

  // ****************************************************************
  // Free running multiplexer cycle counter.
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 8'h00;
    else if (count == MUX_CYCLE_CLKS - 8'h01)
      count <= 8'h00;
    else
      count <= count + 8'h01;
  end

  always_comb
  begin
    boundary = (count == MUX_CYCLE_CLKS - 8'h01);
    compute_busy = (count < COMPUTE_CLKS);
  end

endmodule
